// [rtl/decode_pkg.sv]
// Constants and types for the emulated instruction decoder
// How it works
// - 0,8,3,upper: sum to extension and third
// - 0,8,2,upper: sum accumulator plus third operand
// - 0,8,E,upper: complemented product with third operand
// - 0,8,F,lower: complemented product with extension
// - 0,8,6,upper: exclusive OR with third operand
// - 0,8,7,upper: exclusive OR with extension+third
// - Compare: unequal shorter, equal longer time
// - Decrement loop 2.22 us, plus 0.62 variant
// - Inter-register time depends on destination set
package decode_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int INSTR_W = 16;
  localparam int PRIMARY_MSB = 15;
  localparam int PRIMARY_LSB = 12;
  localparam int SECONDARY_MSB = 11;
  localparam int SECONDARY_LSB = 8;
  localparam int TERTIARY_MSB = 7;
  localparam int TERTIARY_LSB = 4;
  localparam int DEST_MSB = 3;
  localparam int DEST_LSB = 0;
  localparam logic [3:0] GROUP_REGISTER = 4'h0;
  localparam logic [3:0] SEC_SKIP = 4'h1;
  localparam logic [3:0] SEC_INTER_REG = 4'h8;
  localparam logic [3:0] SEC_ENH_STORAGE = 4'h4;
  localparam logic [3:0] SEC_DEC_LOOP = 4'h6;
  localparam logic [3:0] SEC_FIELD = 4'h5;
  localparam logic [3:0] SEC_MISC = 4'hB;
  localparam logic [3:0] SEC_SHIFT = 4'hF;
  localparam logic [3:0] ENH_COMPARE_EQ = 4'hE;
  localparam logic [3:0] TER_SUM_BOTH = 4'h3;
  localparam logic [3:0] TER_SUM_THIRD = 4'h2;
  localparam logic [3:0] TER_CPROD_THIRD = 4'hE;
  localparam logic [3:0] TER_CPROD_EXT = 4'hF;
  localparam logic [3:0] TER_XOR_THIRD = 4'h6;
  localparam logic [3:0] TER_XOR_BOTH = 4'h7;
  // Times in nanoseconds
  localparam int T_CMP_UNEQUAL_NS = 5230;
  localparam int T_CMP_EQUAL_NS = 5460;
  localparam int T_DEC_LOOP_NS = 2220;
  localparam int T_DEC_LOOP_EXTRA_NS = 620;
  localparam int T_IR_FAST_NS = 1180;
  localparam int T_IR_MID_NS = 1340;
  localparam int T_IR_SLOW_NS = 1510;
  localparam int T_SUM_NS_0 = 1740;
  localparam int T_SUM_NS_1 = 1910;
  localparam int T_SUM_NS_2 = 2080;
  localparam int T_SUM_NS_3 = 2250;
  localparam int T_LOG_NS_0 = 1630;
  localparam int T_LOG_NS_1 = 1800;
  localparam int T_LOG_NS_2 = 1960;
  localparam int T_LOG_NS_3 = 2130;
  localparam int CYC_W = 10;
  // Execution figures are nominal, so round down to whole cycles
  function automatic logic [CYC_W-1:0] to_cycles(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    if (c < 1)
    begin
      c = 1;
    end
    return CYC_W'(c);
  endfunction : to_cycles
  typedef enum logic [4:0] {
    OP_NOP, OP_STORAGE, OP_SKIP, OP_SHIFT, OP_INTER_OTHER, OP_SUM_BOTH,
    OP_SUM_THIRD, OP_CPROD_THIRD, OP_CPROD_EXT, OP_XOR_THIRD, OP_XOR_BOTH,
    OP_COMPARE_EQ, OP_ENH_STORAGE, OP_DEC_LOOP, OP_FIELD, OP_MISC, OP_REG_OTHER
  } op_t;
  typedef struct packed {
    logic dest_a;
    logic dest_q;
    logic dest_m;
  } dest_t;
  typedef struct packed {
    op_t op;
    logic [3:0] primary;
    logic [3:0] secondary;
    logic [3:0] tertiary;
    dest_t dest;
    logic [7:0] operand;
  } decode_t;
endpackage : decode_pkg

// [rtl/exec_time.sv]
// Execution time lookup for a decoded operation
`timescale 1ns/100ps
`default_nettype none
module exec_time
  import decode_pkg::*;
(
  input wire op_t op,
  input wire dest_t dest,
  input wire logic operands_equal,
  input wire logic loop_variant,
  output logic [CYC_W-1:0] cycles
);
  logic [1:0] dest_class;
  always_comb
  begin
    // A or Q alone fastest, M involved slower, A+Q third, all three slowest
    if (dest.dest_a && dest.dest_q && dest.dest_m)
      dest_class = 2'd3;
    else if (dest.dest_a && dest.dest_q)
      dest_class = 2'd2;
    else if (dest.dest_m)
      dest_class = 2'd1;
    else
      dest_class = 2'd0;
  end
  always_comb
  begin
    unique case (op)
      OP_COMPARE_EQ:
        cycles = operands_equal ? to_cycles(T_CMP_EQUAL_NS)
                                : to_cycles(T_CMP_UNEQUAL_NS);
      OP_DEC_LOOP:
        cycles = loop_variant ? to_cycles(T_DEC_LOOP_NS + T_DEC_LOOP_EXTRA_NS)
                              : to_cycles(T_DEC_LOOP_NS);
      OP_SUM_BOTH, OP_SUM_THIRD:
        unique case (dest_class)
          2'd0: cycles = to_cycles(T_SUM_NS_0);
          2'd1: cycles = to_cycles(T_SUM_NS_1);
          2'd2: cycles = to_cycles(T_SUM_NS_2);
          default: cycles = to_cycles(T_SUM_NS_3);
        endcase
      OP_CPROD_THIRD, OP_XOR_THIRD, OP_XOR_BOTH:
        unique case (dest_class)
          2'd0: cycles = to_cycles(T_LOG_NS_0);
          2'd1: cycles = to_cycles(T_LOG_NS_1);
          2'd2: cycles = to_cycles(T_LOG_NS_2);
          default: cycles = to_cycles(T_LOG_NS_3);
        endcase
      OP_CPROD_EXT, OP_INTER_OTHER:
        unique case (dest_class)
          2'd0: cycles = to_cycles(T_IR_FAST_NS);
          2'd3: cycles = to_cycles(T_IR_SLOW_NS);
          default: cycles = to_cycles(T_IR_MID_NS);
        endcase
      default:
        cycles = to_cycles(T_IR_FAST_NS);
    endcase
  end
endmodule : exec_time
`default_nettype wire

// [rtl/instr_decode.sv]
// Top-level macro instruction decoder with registered outputs
`timescale 1ns/100ps
`default_nettype none
module instr_decode
  import decode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic operands_equal,
  input wire logic loop_variant,
  output logic decode_valid,
  output decode_t decoded,
  output logic [CYC_W-1:0] exec_cycles
);
  logic [3:0] pri;
  logic [3:0] sec;
  logic [3:0] ter;
  logic [3:0] low;
  logic upper_half;
  op_t next_op;
  dest_t next_dest;
  logic [CYC_W-1:0] next_cycles;
  assign pri = instr[PRIMARY_MSB:PRIMARY_LSB];
  assign sec = instr[SECONDARY_MSB:SECONDARY_LSB];
  assign ter = instr[TERTIARY_MSB:TERTIARY_LSB];
  assign low = instr[DEST_MSB:DEST_LSB];
  assign upper_half = low[3];
  // Inter-register destination bits: bit 2 A, bit 1 Q, bit 0 M
  assign next_dest = '{dest_a: low[2], dest_q: low[1], dest_m: low[0]};
  always_comb
  begin
    next_op = OP_NOP;
    if (pri != GROUP_REGISTER)
      next_op = OP_STORAGE;
    else
    begin
      unique case (sec)
        SEC_SKIP: next_op = OP_SKIP;
        SEC_SHIFT: next_op = OP_SHIFT;
        SEC_FIELD: next_op = OP_FIELD;
        SEC_MISC: next_op = OP_MISC;
        SEC_DEC_LOOP: next_op = OP_DEC_LOOP;
        SEC_ENH_STORAGE:
          next_op = (ter == ENH_COMPARE_EQ) ? OP_COMPARE_EQ : OP_ENH_STORAGE;
        SEC_INTER_REG:
        begin
          next_op = OP_INTER_OTHER;
          if (ter == TER_SUM_BOTH && upper_half)
            next_op = OP_SUM_BOTH;
          else if (ter == TER_SUM_THIRD && upper_half)
            next_op = OP_SUM_THIRD;
          else if (ter == TER_CPROD_THIRD && upper_half)
            next_op = OP_CPROD_THIRD;
          else if (ter == TER_CPROD_EXT && !upper_half)
            next_op = OP_CPROD_EXT;
          else if (ter == TER_XOR_THIRD && upper_half)
            next_op = OP_XOR_THIRD;
          else if (ter == TER_XOR_BOTH && upper_half)
            next_op = OP_XOR_BOTH;
        end
        default: next_op = OP_REG_OTHER;
      endcase
    end
  end
  exec_time u_exec_time (
    .op(next_op),
    .dest(next_dest),
    .operands_equal(operands_equal),
    .loop_variant(loop_variant),
    .cycles(next_cycles)
  );
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      decode_valid <= 1'b0;
    else if (clk_en)
      decode_valid <= instr_valid;
  end
  // Outputs hold the last decode so the sequencer can sample late
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      decoded <= '{op: OP_NOP, primary: 4'h0, secondary: 4'h0, tertiary: 4'h0,
                   dest: '0, operand: 8'h00};
      exec_cycles <= '0;
    end
    else if (clk_en && instr_valid)
    begin
      decoded <= '{op: next_op, primary: pri, secondary: sec, tertiary: ter,
                   dest: next_dest, operand: instr[7:0]};
      exec_cycles <= next_cycles;
    end
  end
endmodule : instr_decode
`default_nettype wire

// [tb/instr_decode_asserts.sv]
// Timing and decode properties of the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module instr_decode_asserts
  import decode_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [INSTR_W-1:0] instr,
  input wire logic operands_equal,
  input wire logic loop_variant,
  input wire logic decode_valid,
  input wire decode_t decoded,
  input wire logic [CYC_W-1:0] exec_cycles
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  logic take;
  logic [11:0] top;
  assign take = clk_en && instr_valid;
  assign top = instr[15:4];
  property p_sum_both;
    take && top == 12'h083 && instr[3] |=> decoded.op == OP_SUM_BOTH;
  endproperty
  a_sum_both: assert property (p_sum_both) else $error("bad sum both");
  property p_sum_third;
    take && top == 12'h082 && instr[3] |=> decoded.op == OP_SUM_THIRD;
  endproperty
  a_sum_third: assert property (p_sum_third) else $error("bad sum third");
  property p_xor_third;
    take && top == 12'h086 && instr[3] |=> decoded.op == OP_XOR_THIRD;
  endproperty
  a_xor_third: assert property (p_xor_third) else $error("bad xor third");
  property p_reset_nop;
    disable iff (1'b0) !rst_b |=> decoded.op == OP_NOP && !decode_valid && exec_cycles == 10'd0;
  endproperty
  a_reset_nop: assert property (p_reset_nop) else $error("bad reset state");
  property p_cprod_third;
    take && top == 12'h08e && instr[3] |=> decoded.op == OP_CPROD_THIRD;
  endproperty
  a_cprod_third: assert property (p_cprod_third) else $error("bad cprod third");
  property p_cprod_ext;
    take && top == 12'h08f && !instr[3] |-> ##1 decoded.op == OP_CPROD_EXT;
  endproperty
  a_cprod_ext: assert property (p_cprod_ext) else $error("bad cprod ext");
  property p_xor_both;
    take && top == 12'h087 && instr[3] |=> decoded.op == OP_XOR_BOTH && decode_valid;
  endproperty
  a_xor_both: assert property (p_xor_both) else $error("bad xor both");
  property p_cmp_time;
    take && top == 12'h04e |=> exec_cycles == ($past(operands_equal) ? 10'd546 : 10'd523);
  endproperty
  a_cmp_time: assert property (p_cmp_time) else $error("bad compare time");
  property p_loop_time;
    take && instr[15:8] == 8'h06 |=> exec_cycles == ($past(loop_variant) ? 10'd284 : 10'd222);
  endproperty
  a_loop_time: assert property (p_loop_time) else $error("bad loop time");
  property p_dest_time;
    take && top == 12'h083 && instr[3:0] == 4'hf |=> exec_cycles == 10'd225;
  endproperty
  a_dest_time: assert property (p_dest_time) else $error("bad destination time");
  property p_storage;
    take && instr[15:12] != 4'h0 |=> decoded.op == OP_STORAGE && decoded.primary == $past(instr[15:12]);
  endproperty
  a_storage: assert property (p_storage) else $error("bad storage decode");
endmodule : instr_decode_asserts
bind instr_decode instr_decode_asserts i_chk (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
  .instr_valid(instr_valid), .instr(instr), .operands_equal(operands_equal),
  .loop_variant(loop_variant), .decode_valid(decode_valid), .decoded(decoded),
  .exec_cycles(exec_cycles));
`default_nettype wire

// [tb/instr_decode_test.sv]
// Self-checking bench for the instruction decoder
`timescale 1ns/100ps
`default_nettype none
module instr_decode_test;
  import decode_pkg::*;
  logic sys_clk = 0, rst_b = 0, clk_en = 1, instr_valid = 0, eq = 0, lv = 0, en_s;
  logic [INSTR_W-1:0] instr = 0;
  logic decode_valid;
  decode_t decoded;
  logic [CYC_W-1:0] exec_cycles;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic [31:0] seed = 32'h6831_3f94;
  logic [3:0] p;
  logic [2:0] d;
  int fail_count = 0, cmp_count = 0, tick = 0, c;
  int t_sum[4] = '{174, 191, 208, 225};
  int t_log[4] = '{163, 180, 196, 213};
  int t_oth[4] = '{118, 134, 134, 151};
  instr_decode i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .instr_valid(instr_valid),
    .instr(instr), .operands_equal(eq), .loop_variant(lv), .decode_valid(decode_valid),
    .decoded(decoded), .exec_cycles(exec_cycles));
  initial forever #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic int cls(input logic [2:0] v);
    return v[0] ? ((v[2] && v[1]) ? 3 : 1) : ((v[2] && v[1]) ? 2 : 0);
  endfunction : cls
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    cmp_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic send(input logic [15:0] iw, input logic [15:0] e);
    @(posedge sys_clk);
    #1;
    clk_en = 1;
    instr_valid = 1;
    instr = iw;
    // Side inputs change only with the word they belong to
    eq = seed[8];
    lv = seed[9];
    exp_q.push_back({iw, e});
  endtask : send
  always @(posedge sys_clk)
  begin
    tick++;
    if (tick == 3000)
    begin
      fail_count++;
      close_out();
    end
  end
  // Frozen edges repeat the old result, so only enabled edges consume a note
  always @(posedge sys_clk)
  begin
    en_s = clk_en;
    #2;
    if (rst_b && en_s && decode_valid === 1'b1)
    begin
      w = exp_q.pop_front();
      check(10'(decoded.op), 10'(w[14:10]));
      if (w[15])
        check(exec_cycles, w[9:0]);
      check(10'({decoded.primary, decoded.secondary}), 10'(w[31:24]));
      check(10'(decoded.operand), 10'(w[23:16]));
      check(10'({decoded.tertiary, decoded.dest}), 10'({w[23:20], w[18:16]}));
    end
  end
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    check(10'(decoded.op), 10'(OP_NOP));
    rst_b = 1;
    send(16'h083b, {1'b1, OP_SUM_BOTH, 10'd191});
    for (int i = 0; i < 200; i++)
    begin
      seed = lfsr(seed);
      d = (seed[2:0] == 3'b000) ? 3'b001 : seed[2:0];
      c = cls(d);
      p = (seed[27:24] == 4'h0) ? 4'h1 : seed[27:24];
      case (seed[13:10])
        0: send({8'h08, 4'h3, 1'b1, d}, {1'b1, OP_SUM_BOTH, 10'(t_sum[c])});
        1: send({8'h08, 4'h2, 1'b1, d}, {1'b1, OP_SUM_THIRD, 10'(t_sum[c])});
        2: send({8'h08, 4'he, 1'b1, d}, {1'b1, OP_CPROD_THIRD, 10'(t_log[c])});
        3: send({8'h08, 4'hf, 1'b0, d}, {1'b1, OP_CPROD_EXT, 10'(t_oth[c])});
        4: send({8'h08, 4'h6, 1'b1, d}, {1'b1, OP_XOR_THIRD, 10'(t_log[c])});
        5: send({8'h08, 4'h7, 1'b1, d}, {1'b1, OP_XOR_BOTH, 10'(t_log[c])});
        6: send({8'h04, 4'he, seed[19:16]}, {1'b1, OP_COMPARE_EQ, (seed[8] ? 10'd546 : 10'd523)});
        7: send({8'h06, seed[23:16]}, {1'b1, OP_DEC_LOOP, (seed[9] ? 10'd284 : 10'd222)});
        default: send({p, seed[31:20]}, {1'b1, OP_STORAGE, 10'd118});
      endcase
      if (seed[30])
      begin
        @(posedge sys_clk);
        #1;
        clk_en = seed[29];
        instr_valid = ~seed[29];
        instr = ~instr;
      end
    end
    @(posedge sys_clk);
    #1;
    instr_valid = 0;
    repeat (3) @(posedge sys_clk);
    #3;
    check(10'(exp_q.size()), 10'd0);
    close_out();
  end
endmodule : instr_decode_test
`default_nettype wire
